// file: ocdt_pkg.sv
// Package: register map, field layout and codes of the one-count delay / one-shot timer
package ocdt_pkg;
    localparam logic [3:0] ADDR_MASTER_MODE  = 4'h0;
    localparam logic [3:0] ADDR_SLAVE_MODE   = 4'h1;
    localparam logic [3:0] ADDR_MASTER_RELOAD = 4'h2;
    localparam logic [3:0] ADDR_SLAVE_RELOAD = 4'h3;
    localparam logic [3:0] ADDR_START        = 4'h4;
    localparam logic [3:0] ADDR_STOP         = 4'h5;
    localparam logic [3:0] ADDR_STATUS       = 4'h6;
    localparam logic [3:0] ADDR_MASTER_COUNT = 4'h7;
    localparam logic [3:0] ADDR_SLAVE_COUNT  = 4'h8;
    localparam logic [3:0] ADDR_OUT_CTRL     = 4'h9;
    localparam logic [3:0] ADDR_PRESCALE     = 4'hA;
    localparam logic [3:0] ADDR_POWER        = 4'hB;

    localparam int OP_MODE_LSB    = 0;
    localparam int RESTART_BIT    = 0;
    localparam int EDGE_SEL_LSB   = 6;
    localparam int TRIG_SRC_LSB   = 8;
    localparam int SPLIT_BIT      = 11;
    localparam int CLK_SEL_LSB    = 14;
    localparam int START_HI_BIT   = 2;
    localparam int POL_BIT        = 1;
    localparam int OUT_EN_BIT     = 0;

    localparam logic [3:0]  MODE_ONE_COUNT = 4'h8;
    localparam logic [1:0]  EDGE_FALL      = 2'h0;
    localparam logic [1:0]  EDGE_RISE      = 2'h1;
    localparam logic [1:0]  EDGE_BOTH      = 2'h2;
    localparam logic [2:0]  SRC_SOFTWARE   = 3'h0;
    localparam logic [2:0]  SRC_EXT_EDGE   = 3'h1;
    localparam logic [2:0]  SRC_MASTER_IRQ = 3'h4;
    localparam logic [15:0] MODE_RESET     = 16'h0000;
    localparam logic [15:0] RELOAD_RESET   = 16'h0000;
    localparam logic [15:0] PRESCALE_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ocdt_bus_t;
endpackage

// file: ocdt_timer.sv
// Design: paired one-count channels forming delay counter and one-shot pulse
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - External valid edge starts down count, then interrupt
// - Software start while enabled also starts count
// - Interval equals count period times reload plus one
// - Mode code 1000B makes counter count down
// - Start bit sets enable, waits for trigger
// - Trigger loads reload value, then decrements
// - At zero raise interrupt, wait next trigger
// - Reload writable anytime, used next period
// - Mode bit ignores or accepts retrigger
// - Edge field: falling, rising, both; 11B prohibited
// - Source 001B selects external input edge
// - Split bit: 16-bit or 8-bit operation; here it only gates clocks 2 and 3, counting stays 16-bit
// - Clock field picks prescaled clock zero to three
// - Stop bit clears enable, holds counter
// - Power off stops, blocks writes, initializes
// - One-shot delay equals master reload plus two
// - Pulse width equals slave reload value
// - Master runs one-count, timing the delay
// - Slave starts on master interrupt, counts down
// - Output active one clock after master interrupt
// - Master software start also launches pulse
// - Polarity bit: 0 active-high, 1 active-low
module ocdt_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_in,
    input  wire ocdt_pkg::ocdt_bus_t  bus_in,
    output logic [15:0]               rdata_out,
    input  wire logic                 ext_trigger_in,
    output logic                      chan_done_irq_out,
    output logic                      slave_done_irq_out,
    output logic                      pulse_output_out
);
    if (CNT_W != 16) begin : g_chk
        $error("CNT_W must be 16");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic        unit_power_enable;
    logic [15:0] channel_mode_config [2];
    logic [15:0] reload_value [2];
    logic [15:0] chan_counter [2];
    logic [1:0]  chan_enable_status;
    logic        hi_byte_enable_status;
    logic [1:0]  counting;
    logic        output_polarity;
    logic        output_enable;
    logic [15:0] prescaler_select;
    logic [15:0] presc;
    logic        trig_q;
    logic        pulse_level;
    logic        pending_active;

    logic        wr_ok;
    logic [1:0]  start_wr;
    logic [1:0]  stop_wr;
    logic [3:0]  tick_vec;
    logic [1:0]  tick;
    logic [1:0]  trig;
    logic [1:0]  done;
    logic        edge_hit;

    assign wr_ok = bus_in.wr && unit_power_enable;
    assign start_wr = (wr_ok && bus_in.addr == ocdt_pkg::ADDR_START)
                      ? bus_in.wdata[1:0] : 2'h0;
    assign stop_wr  = (wr_ok && bus_in.addr == ocdt_pkg::ADDR_STOP)
                      ? bus_in.wdata[1:0] : 2'h0;

    // ------------------------------------------------------------
    // Prescaler: four count clocks from one free counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            presc <= 16'h0000;
        end else if (!unit_power_enable) begin
            presc <= 16'h0000;
        end else begin
            presc <= presc + 16'h0001;
        end
    end

    // Each prescaled clock is a one-cycle enable when its masked bits are all ones
    function automatic logic presc_tick(input logic [15:0] cnt, input logic [3:0] sel);
        logic [15:0] mask;
        mask = (16'h0001 << sel) - 16'h0001;
        presc_tick = (cnt & mask) == mask;
    endfunction

    always_comb begin
        tick_vec[0] = presc_tick(presc, prescaler_select[3:0]);
        tick_vec[1] = presc_tick(presc, prescaler_select[7:4]);
        tick_vec[2] = presc_tick(presc, prescaler_select[11:8]);
        tick_vec[3] = presc_tick(presc, prescaler_select[15:12]);
    end

    // Clocks 2 and 3 only in 8-bit split operation, else fall back to clock 0
    function automatic logic pick_tick(input logic [15:0] cfg, input logic [3:0] tv);
        logic [1:0] sel;
        sel = cfg[ocdt_pkg::CLK_SEL_LSB +: 2];
        case (sel)
            2'h0: pick_tick = tv[0];
            2'h2: pick_tick = tv[1];
            2'h1: pick_tick = cfg[ocdt_pkg::SPLIT_BIT] ? tv[2] : tv[0];
            default: pick_tick = cfg[ocdt_pkg::SPLIT_BIT] ? tv[3] : tv[0];
        endcase
    endfunction

    assign tick[0] = pick_tick(channel_mode_config[0], tick_vec);
    assign tick[1] = pick_tick(channel_mode_config[1], tick_vec);

    // ------------------------------------------------------------
    // Edge detect on the external trigger
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= ext_trigger_in;
        end
    end

    always_comb begin
        case (channel_mode_config[0][ocdt_pkg::EDGE_SEL_LSB +: 2])
            ocdt_pkg::EDGE_FALL: edge_hit = trig_q && !ext_trigger_in;
            ocdt_pkg::EDGE_RISE: edge_hit = !trig_q && ext_trigger_in;
            ocdt_pkg::EDGE_BOTH: edge_hit = trig_q != ext_trigger_in;
            default:             edge_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Triggers per channel
    // ------------------------------------------------------------
    function automatic logic src_trig(input logic [15:0] cfg, input logic sw,
                                      input logic ext, input logic mirq);
        logic [2:0] src;
        src = cfg[ocdt_pkg::TRIG_SRC_LSB +: 3];
        src_trig = sw;
        if (src == ocdt_pkg::SRC_EXT_EDGE) begin
            src_trig = sw || ext;
        end else if (src == ocdt_pkg::SRC_MASTER_IRQ) begin
            src_trig = mirq;
        end
    endfunction

    always_comb begin
        // Software start on an enabled channel is a trigger unless its source is the master interrupt, else it only enables
        trig[0] = chan_enable_status[0] && (!counting[0] ||
                  channel_mode_config[0][ocdt_pkg::RESTART_BIT]) &&
                  src_trig(channel_mode_config[0], start_wr[0], edge_hit, 1'b0);
        trig[1] = chan_enable_status[1] && (!counting[1] ||
                  channel_mode_config[1][ocdt_pkg::RESTART_BIT]) &&
                  src_trig(channel_mode_config[1], start_wr[1], edge_hit,
                           chan_done_irq_out);
    end

    // ------------------------------------------------------------
    // Channel counters, one generate per channel
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_ch
        always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
                chan_counter[c] <= ocdt_pkg::COUNT_ZERO;
                counting[c] <= 1'b0;
            end else if (!unit_power_enable) begin
                chan_counter[c] <= ocdt_pkg::COUNT_ZERO;
                counting[c] <= 1'b0;
            end else if (!chan_enable_status[c] || stop_wr[c]) begin
                counting[c] <= 1'b0;
            end else if (trig[c]) begin
                chan_counter[c] <= reload_value[c];
                counting[c] <= 1'b1;
            end else if (counting[c] && tick[c] &&
                         channel_mode_config[c][3:0] == ocdt_pkg::MODE_ONE_COUNT) begin
                if (chan_counter[c] == ocdt_pkg::COUNT_ZERO) begin
                    counting[c] <= 1'b0;
                end else begin
                    chan_counter[c] <= chan_counter[c] - 16'h0001;
                end
            end
        end
        assign done[c] = unit_power_enable && chan_enable_status[c] && !stop_wr[c] &&
                         !trig[c] && counting[c] && tick[c] &&
                         chan_counter[c] == ocdt_pkg::COUNT_ZERO;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            chan_done_irq_out <= 1'b0;
            slave_done_irq_out <= 1'b0;
        end else begin
            chan_done_irq_out <= done[0];
            slave_done_irq_out <= done[1];
        end
    end

    // ------------------------------------------------------------
    // Enable status
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            chan_enable_status <= 2'h0;
            hi_byte_enable_status <= 1'b0;
        end else if (!unit_power_enable) begin
            chan_enable_status <= 2'h0;
            hi_byte_enable_status <= 1'b0;
        end else begin
            chan_enable_status <= (chan_enable_status | start_wr) & ~stop_wr;
            // Stop beats start in one cycle, as for the channel enables
            if (stop_wr[1]) begin
                hi_byte_enable_status <= 1'b0;
            end else if (wr_ok && bus_in.addr == ocdt_pkg::ADDR_START &&
                         bus_in.wdata[ocdt_pkg::START_HI_BIT]) begin
                hi_byte_enable_status <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Slave pulse: active one count clock after master done
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pulse_level <= 1'b0;
            pending_active <= 1'b0;
        end else if (!unit_power_enable) begin
            pulse_level <= 1'b0;
            pending_active <= 1'b0;
        end else begin
            if (trig[1]) begin
                pending_active <= 1'b1;
            end else if (pending_active && tick[1]) begin
                pending_active <= 1'b0;
                pulse_level <= 1'b1;
            end
            if (done[1] && !pending_active) begin
                pulse_level <= 1'b0;
            end
        end
    end

    // Output held at its level while the output is disabled with power on; power off clears it to 0
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pulse_output_out <= 1'b0;
        end else if (!unit_power_enable) begin
            pulse_output_out <= 1'b0;
        end else if (output_enable) begin
            pulse_output_out <= pulse_level ^ output_polarity;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            unit_power_enable <= 1'b0;
        end else if (bus_in.wr && bus_in.addr == ocdt_pkg::ADDR_POWER) begin
            unit_power_enable <= bus_in.wdata[0];
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_mode_config[0] <= ocdt_pkg::MODE_RESET;
            channel_mode_config[1] <= ocdt_pkg::MODE_RESET;
            reload_value[0] <= ocdt_pkg::RELOAD_RESET;
            reload_value[1] <= ocdt_pkg::RELOAD_RESET;
            output_polarity <= 1'b0;
            output_enable <= 1'b0;
            prescaler_select <= ocdt_pkg::PRESCALE_RESET;
        end else if (!unit_power_enable) begin
            channel_mode_config[0] <= ocdt_pkg::MODE_RESET;
            channel_mode_config[1] <= ocdt_pkg::MODE_RESET;
            reload_value[0] <= ocdt_pkg::RELOAD_RESET;
            reload_value[1] <= ocdt_pkg::RELOAD_RESET;
            output_polarity <= 1'b0;
            output_enable <= 1'b0;
            prescaler_select <= ocdt_pkg::PRESCALE_RESET;
        end else if (wr_ok) begin
            if (bus_in.addr == ocdt_pkg::ADDR_MASTER_MODE) begin
                channel_mode_config[0] <= bus_in.wdata;
            end else if (bus_in.addr == ocdt_pkg::ADDR_SLAVE_MODE) begin
                channel_mode_config[1] <= bus_in.wdata;
            end else if (bus_in.addr == ocdt_pkg::ADDR_MASTER_RELOAD) begin
                reload_value[0] <= bus_in.wdata;
            end else if (bus_in.addr == ocdt_pkg::ADDR_SLAVE_RELOAD) begin
                reload_value[1] <= bus_in.wdata;
            end else if (bus_in.addr == ocdt_pkg::ADDR_OUT_CTRL) begin
                output_polarity <= bus_in.wdata[ocdt_pkg::POL_BIT];
                output_enable <= bus_in.wdata[ocdt_pkg::OUT_EN_BIT];
            end else if (bus_in.addr == ocdt_pkg::ADDR_PRESCALE) begin
                prescaler_select <= bus_in.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads, data in the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 16'h0000;
        end else if (!bus_in.rd) begin
            rdata_out <= 16'h0000;
        end else if (bus_in.addr == ocdt_pkg::ADDR_MASTER_MODE) begin
            rdata_out <= channel_mode_config[0];
        end else if (bus_in.addr == ocdt_pkg::ADDR_SLAVE_MODE) begin
            rdata_out <= channel_mode_config[1];
        end else if (bus_in.addr == ocdt_pkg::ADDR_MASTER_RELOAD) begin
            rdata_out <= reload_value[0];
        end else if (bus_in.addr == ocdt_pkg::ADDR_SLAVE_RELOAD) begin
            rdata_out <= reload_value[1];
        end else if (bus_in.addr == ocdt_pkg::ADDR_STATUS) begin
            rdata_out <= {11'h000, counting, hi_byte_enable_status, chan_enable_status};
        end else if (bus_in.addr == ocdt_pkg::ADDR_MASTER_COUNT) begin
            rdata_out <= chan_counter[0];
        end else if (bus_in.addr == ocdt_pkg::ADDR_SLAVE_COUNT) begin
            rdata_out <= chan_counter[1];
        end else if (bus_in.addr == ocdt_pkg::ADDR_OUT_CTRL) begin
            rdata_out <= {14'h0000, output_polarity, output_enable};
        end else if (bus_in.addr == ocdt_pkg::ADDR_PRESCALE) begin
            rdata_out <= prescaler_select;
        end else if (bus_in.addr == ocdt_pkg::ADDR_POWER) begin
            rdata_out <= {15'h0000, unit_power_enable};
        end else begin
            rdata_out <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_stop_clears;
        @(posedge sys_clk_in) disable iff (rst_in)
        stop_wr[0] |=> !chan_enable_status[0];
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop did not clear enable");

    property p_start_sets;
        @(posedge sys_clk_in) disable iff (rst_in)
        (start_wr[0] && !stop_wr[0]) |=> chan_enable_status[0];
    endproperty
    a_start_sets: assert property (p_start_sets) else $error("start did not set enable");

    property p_load;
        @(posedge sys_clk_in) disable iff (rst_in)
        trig[0] && !stop_wr[0] |=> chan_counter[0] == $past(reload_value[0]);
    endproperty
    a_load: assert property (p_load) else $error("reload not loaded");

    property p_irq_zero;
        @(posedge sys_clk_in) disable iff (rst_in)
        chan_done_irq_out |-> $past(chan_counter[0]) == 16'h0000;
    endproperty
    a_irq_zero: assert property (p_irq_zero) else $error("irq without zero count");

    property p_disabled_hold;
        @(posedge sys_clk_in) disable iff (rst_in)
        (!chan_enable_status[0] && unit_power_enable && $stable(unit_power_enable))
            |=> $stable(chan_counter[0]);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("disabled counter moved");

    property p_power_off;
        @(posedge sys_clk_in) disable iff (rst_in)
        !unit_power_enable |=> chan_enable_status == 2'h0 && reload_value[0] == 16'h0000;
    endproperty
    a_power_off: assert property (p_power_off) else $error("power off not initialising");

    property p_down;
        @(posedge sys_clk_in) disable iff (rst_in)
        (counting[0] && tick[0] && !trig[0] && chan_enable_status[0] && !stop_wr[0] &&
         unit_power_enable && chan_counter[0] != 16'h0000 &&
         channel_mode_config[0][3:0] == ocdt_pkg::MODE_ONE_COUNT)
            |=> chan_counter[0] == $past(chan_counter[0]) - 16'h0001;
    endproperty
    a_down: assert property (p_down) else $error("counter did not decrement");

    property p_slave_start;
        @(posedge sys_clk_in) disable iff (rst_in)
        (trig[1] && !stop_wr[1]) |=> counting[1] && pending_active;
    endproperty
    a_slave_start: assert property (p_slave_start) else $error("slave did not start");

    property p_no_retrig;
        @(posedge sys_clk_in) disable iff (rst_in)
        (counting[0] && !channel_mode_config[0][ocdt_pkg::RESTART_BIT])
            |=> chan_counter[0] <= $past(chan_counter[0]);
    endproperty
    a_no_retrig: assert property (p_no_retrig) else $error("retrigger accepted");

    c_master_done: cover property (@(posedge sys_clk_in) chan_done_irq_out);
    c_slave_done:  cover property (@(posedge sys_clk_in) slave_done_irq_out);
    c_pulse:       cover property (@(posedge sys_clk_in) pulse_level ##1 !pulse_level);
endmodule

// file: ocdt_timer_tb_top.sv
// Testbench: power, delay count, edge select, stop and one-shot scenarios
`timescale 1ns/1ns
module ocdt_timer_tb_top;
    logic                sys_clk_in;
    logic                rst_in;
    ocdt_pkg::ocdt_bus_t bus_in;
    logic [15:0]         rdata_out;
    logic                ext_trigger_in;
    logic                chan_done_irq_out;
    logic                slave_done_irq_out;
    logic                pulse_output_out;
    logic                fire;
    logic                lvl;
    logic [15:0]         d0;
    logic [15:0]         d1;
    int                  failures;
    int                  checks;
    int                  cycles;
    int                  n0;
    int                  n1;

    ocdt_timer uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in),
        .rdata_out(rdata_out), .ext_trigger_in(ext_trigger_in),
        .chan_done_irq_out(chan_done_irq_out), .slave_done_irq_out(slave_done_irq_out),
        .pulse_output_out(pulse_output_out));
    ocdt_trig_model trig (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .fire_in(fire),
        .ext_trigger_out(ext_trigger_in));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial sys_clk_in = 1'b0;
    always #50 sys_clk_in = ~sys_clk_in;

    // A hang anywhere lands in the same closing report
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        bus_in.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk_in);
        bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        bus_in.rd <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic fire_edge();
        @(posedge sys_clk_in);
        fire <= 1'b1;
        lvl = ~lvl;
        @(posedge sys_clk_in);
        fire <= 1'b0;
    endtask

    task automatic wait_irq(input int max, output int n);
        n = 0;
        while (n < max) begin
            @(posedge sys_clk_in);
            #1 n++;
            if (chan_done_irq_out === 1'b1) break;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power();
        wr(ocdt_pkg::ADDR_MASTER_RELOAD, 16'h1234);
        wr(ocdt_pkg::ADDR_POWER, 16'h0001);
        rd(ocdt_pkg::ADDR_MASTER_RELOAD, d0);
        check("reload write while off", d0, ocdt_pkg::RELOAD_RESET);
        rd(4'hC, d0);
        check("unmapped read", d0, 16'h0000);
    endtask

    task automatic t_delay();
        wr(ocdt_pkg::ADDR_MASTER_MODE, 16'h0188);
        wr(ocdt_pkg::ADDR_START, 16'h0001);
        rd(ocdt_pkg::ADDR_STATUS, d0);
        check("enable after start", d0 & 16'h0001, 16'h0001);
        wr(ocdt_pkg::ADDR_MASTER_RELOAD, 16'h0003);
        fire_edge();
        wait_irq(200, n0);
        wr(ocdt_pkg::ADDR_MASTER_RELOAD, 16'h0007);
        fire_edge();
        wait_irq(200, n1);
        check("interval grows with reload", 16'(n1 - n0), 16'h0004);
        rd(ocdt_pkg::ADDR_MASTER_COUNT, d0);
        check("counter idles at zero", d0, ocdt_pkg::COUNT_ZERO);
        wr(ocdt_pkg::ADDR_START, 16'h0001);
        wait_irq(200, n0);
        check("software start interval", 16'(n0), 16'h0008);
    endtask

    task automatic t_edge();
        for (int m = 0; m < 3; m++) begin
            // Mode 0 is not one-count, so an edge may load it but neither edge may bring an interrupt
            wr(ocdt_pkg::ADDR_MASTER_MODE, (m == 2) ? 16'h0180 : 16'h0108 | 16'(m << 6));
            for (int k = 0; k < 2; k++) begin
                fire_edge();
                wait_irq(30, n0);
                check("edge select", 16'(n0 < 30), 16'(m != 2 && lvl == m));
            end
        end
    endtask

    task automatic t_stop();
        // The last edge scenario leaves the master counting in a dead mode
        wr(ocdt_pkg::ADDR_STOP, 16'h0001);
        wr(ocdt_pkg::ADDR_MASTER_MODE, 16'h0188);
        wr(ocdt_pkg::ADDR_MASTER_RELOAD, 16'h00FF);
        wr(ocdt_pkg::ADDR_START, 16'h0001);
        fire_edge();
        repeat (6) @(posedge sys_clk_in);
        wr(ocdt_pkg::ADDR_STOP, 16'h0001);
        rd(ocdt_pkg::ADDR_MASTER_COUNT, d0);
        check("counter value at stop", d0, 16'h00F9);
        repeat (5) @(posedge sys_clk_in);
        rd(ocdt_pkg::ADDR_MASTER_COUNT, d1);
        check("counter held after stop", d1, d0);
        rd(ocdt_pkg::ADDR_STATUS, d1);
        check("enable cleared by stop", d1 & 16'h0001, 16'h0000);
        fire_edge();
        wait_irq(300, n0);
        check("disabled ignores edge", 16'(n0 < 300), 16'h0000);
    endtask

    task automatic t_oneshot();
        wr(ocdt_pkg::ADDR_MASTER_RELOAD, 16'h0002);
        wr(ocdt_pkg::ADDR_SLAVE_MODE, 16'h0408);
        wr(ocdt_pkg::ADDR_SLAVE_RELOAD, 16'h0005);
        wr(ocdt_pkg::ADDR_OUT_CTRL, 16'h0001);
        wr(ocdt_pkg::ADDR_START, 16'h0003);
        fire_edge();
        wait_irq(50, n0);
        n0 = 0;
        while (pulse_output_out !== 1'b1 && n0 < 10) begin
            @(posedge sys_clk_in);
            #1 n0++;
        end
        check("pulse follows master done", 16'(n0 >= 1 && n0 <= 3), 16'h0001);
        n1 = 0;
        d1 = 16'h0000;
        while (pulse_output_out === 1'b1 && n1 < 50) begin
            @(posedge sys_clk_in);
            #1 n1++;
            if (slave_done_irq_out === 1'b1) d1 = 16'h0001;
        end
        check("pulse width", 16'(n1), 16'h0005);
        check("slave done irq", d1, 16'h0001);
        wr(ocdt_pkg::ADDR_OUT_CTRL, 16'h0003);
        repeat (3) @(posedge sys_clk_in);
        check("inverted idle level", {15'h0000, pulse_output_out}, 16'h0001);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        bus_in = '0;
        fire = 1'b0;
        lvl = 1'b0;
        failures = 0;
        checks = 0;
        cycles = 0;
        rst_in = 1'b1;
        repeat (5) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_power();
        t_delay();
        t_edge();
        t_stop();
        t_oneshot();
        complete_run();
    end
endmodule

// file: ocdt_trig_model.sv
// Partner model: external trigger source that flips its level on request
`timescale 1ns/1ns
module ocdt_trig_model (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic fire_in,
    output logic      ext_trigger_out
);
    // Level moves only just after a clock edge, like a synchronous source
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ext_trigger_out <= 1'b0;
        end else if (fire_in) begin
            ext_trigger_out <= ~ext_trigger_out;
        end
    end
endmodule
